// [hdl/wim_cfg.svh]
// wake input monitor: register offsets, field positions, codes, response values, timing
// assumes inclusion by the top module only
`ifndef WIM_CFG_SVH
`define WIM_CFG_SVH
`define WIM_OFS_ENABLE     12'h000
`define WIM_OFS_PULL       12'h004
`define WIM_OFS_FILTER     12'h008
`define WIM_OFS_SRC        12'h00C
`define WIM_OFS_AUX_SRC    12'h010
`define WIM_OFS_LEVEL      12'h014
`define WIM_OFS_MODE       12'h018
`define WIM_OFS_MASK       12'h01C
`define WIM_OFS_AUX_MASK   12'h020
`define WIM_MODE_MEAS_BIT  3
`define WIM_MODE_FAIL_BIT  4
`define WIM_PULL_NONE      2'h0
`define WIM_PULL_DOWN      2'h1
`define WIM_PULL_UP        2'h2
`define WIM_PULL_AUTO      2'h3
`define WIM_FLT_SHORT      2'h0
`define WIM_FLT_LONG       2'h1
`define WIM_FLT_CYC1       2'h2
`define WIM_FLT_CYC2       2'h3
`define WIM_CLK_MHZ        200
`define WIM_T_SHORT_US     16
`define WIM_T_LONG_US      64
`define WIM_CYC_SHORT      (`WIM_T_SHORT_US * `WIM_CLK_MHZ)
`define WIM_CYC_LONG       (`WIM_T_LONG_US * `WIM_CLK_MHZ)
`define WIM_RESP_OKAY      2'h0
`define WIM_RESP_SLVERR    2'h2
`endif

// [hdl/wim_pkg.sv]
// wake input monitor: shared types
// assumes wim_cfg.svh holds all numeric constants
package wim_pkg;
	typedef enum logic [1:0] {
		WIM_NORMAL   = 2'h0,
		WIM_STOP     = 2'h1,
		WIM_SLEEP    = 2'h2,
		WIM_FAILSAFE = 2'h3
	} wim_mode_t;

	typedef enum logic [1:0] {
		WIM_BUS_IDLE = 2'h0,
		WIM_BUS_WR   = 2'h1,
		WIM_BUS_RD   = 2'h2
	} wim_bus_t;

	typedef struct packed {
		logic [2:0] enable;
		logic [5:0] pull;
		logic [5:0] filter;
		logic       meas;
		logic [2:0] irq_mask;
		logic [1:0] aux_mask;
	} wim_ctrl_t;

	typedef struct packed {
		logic pull_up;
		logic pull_down;
	} wim_pull_t;
endpackage : wim_pkg

// [hdl/wim_wake_input_monitor.sv]
// wake input monitor: filters, edge detection, flags, AXI4-Lite registers
// assumes pins are async, timer on-window pulses are synchronous to clk
//
// Contract
// - three wake inputs, each with own enable, pull and filter setting
// - rising and falling edges both signal
// - normal/stop raises interrupt; sleep/fail-safe wakes device
// - static sensing continuous; cyclic sensing only inside timer window
// - static sensing offers 16 us or 64 us deglitch
// - filter restarts on crossing; edge recognised when stable for full time
// - per-pin wake enable register written by software
// - sticky per-pin wake source flags readable always
// - live level readable in normal and stop regardless of enable
// - cyclic sensing reports sampled level, not live level
// - aux wake inputs use fixed 16 us filter, separate flag register
// - pull code 00 none, 01 pull-down, 10 pull-up
// - pull code 11 follows detected level: high pull-up, low pull-down
// - filter codes 00 short static, 01 long static
// - codes 10/11 cyclic with first/second timer, short filter
// - measurement gates pins one and two: no pull, no flag, no level update
// - sleep with only pins one/two enabled under measurement is refused: fail flag set, restart pulsed
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "wim_cfg.svh"
module wim_wake_input_monitor #(
	parameter int N_WAKE = 3,
	parameter int N_AUX  = 2,
	parameter int T_SHORT_CYC = `WIM_CYC_SHORT,
	parameter int T_LONG_CYC  = `WIM_CYC_LONG
) (
	input  wire logic                 clk,
	input  wire logic                 reset_n,
	input  wire logic [N_WAKE-1:0]    wake_pin,
	input  wire logic [N_AUX-1:0]     aux_wake_pin,
	input  wire logic [1:0]           timer_on,
	input  wire logic                 sleep_request,
	output logic [2*N_WAKE-1:0]       pull_drive,
	output logic                      wake_up,
	output logic                      restart,
	output logic                      irq,
	input  wire logic [11:0]          s_axi_awaddr,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	input  wire logic [31:0]          s_axi_wdata,
	input  wire logic [3:0]           s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	input  wire logic [11:0]          s_axi_araddr,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	output logic [31:0]               s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready
);
	// elaboration-time refusal of pin counts the fixed control fields cannot hold and of bad filter lengths
	if (N_WAKE != 3) begin : g_bad_wake
		$error("wim: N_WAKE must be 3");
	end
	if (N_AUX != 2) begin : g_bad_aux
		$error("wim: N_AUX must be 2");
	end
	if (T_SHORT_CYC < 1) begin : g_bad_short
		$error("wim: short filter must be at least one cycle");
	end
	if (T_LONG_CYC < T_SHORT_CYC) begin : g_bad_long
		$error("wim: long filter shorter than short filter");
	end

	localparam int CW = $clog2(T_LONG_CYC + 1);

	typedef struct packed {
		wim_pkg::wim_ctrl_t   ctrl;
		wim_pkg::wim_mode_t   mode;
		logic [N_WAKE-1:0]    sync1;
		logic [N_WAKE-1:0]    sync2;
		logic [N_AUX-1:0]     async1;
		logic [N_AUX-1:0]     async2;
		logic [1:0]           ton_d;
		logic [N_WAKE-1:0]    stable;
		logic [N_WAKE*CW-1:0] cnt;
		logic [N_AUX-1:0]     astable;
		logic [N_AUX*CW-1:0]  acnt;
		logic [N_WAKE-1:0]    level;
		logic [N_WAKE-1:0]    src;
		logic [N_AUX-1:0]     aux_src;
		logic                 fail;
		logic                 sleep_d;
		logic [2*N_WAKE-1:0]  pull_drive;
		logic                 wake_up;
		logic                 restart;
		logic                 irq;
		logic                 aw_got;
		logic                 w_got;
		logic [11:0]          awaddr;
		logic [31:0]          wdata;
		logic [3:0]           wstrb;
		logic                 bvalid;
		logic [1:0]           bresp;
		logic                 rvalid;
		logic [31:0]          rdata;
		logic [1:0]           rresp;
		logic                 awready;
		logic                 wready;
		logic                 arready;
	} wim_state_t;

	wim_state_t st;
	wim_state_t next_st;

	function automatic wim_pkg::wim_pull_t pull_decode(input logic [1:0] code, input logic lvl);
		wim_pkg::wim_pull_t p;
		p.pull_up   = (code == `WIM_PULL_UP) || (code == `WIM_PULL_AUTO && lvl);
		p.pull_down = (code == `WIM_PULL_DOWN) || (code == `WIM_PULL_AUTO && !lvl);
		return p;
	endfunction : pull_decode

	function automatic logic known_offset(input logic [11:0] a);
		return a == `WIM_OFS_ENABLE || a == `WIM_OFS_PULL || a == `WIM_OFS_FILTER
			|| a == `WIM_OFS_SRC || a == `WIM_OFS_AUX_SRC || a == `WIM_OFS_LEVEL
			|| a == `WIM_OFS_MODE || a == `WIM_OFS_MASK || a == `WIM_OFS_AUX_MASK;
	endfunction : known_offset

	// recognised edges that count as wake sources
	function automatic logic [N_WAKE-1:0] enabled_hits(input logic [N_WAKE-1:0] hit,
		input logic [N_WAKE-1:0] en, input logic [N_WAKE-1:0] gt);
		return hit & en & ~gt;
	endfunction : enabled_hits

	always_comb begin
		logic [N_WAKE-1:0] edge_hit;
		logic [N_AUX-1:0]  aux_hit;
		logic [N_WAKE-1:0] gate;
		logic [N_WAKE-1:0] clr_src;
		logic [N_AUX-1:0]  clr_aux;
		logic [CW-1:0]     c;
		logic [CW-1:0]     lim;
		logic [1:0]        fc;
		logic              cyc;
		logic              smp;
		logic              do_wr;
		logic              low_power;
		logic [31:0]       rd;
		wim_pkg::wim_pull_t p;
		edge_hit  = '0;
		aux_hit   = '0;
		clr_src   = '0;
		clr_aux   = '0;
		c         = '0;
		lim       = '0;
		fc        = '0;
		cyc       = 1'b0;
		smp       = 1'b0;
		rd        = '0;
		p         = '0;
		gate      = '0;
		do_wr     = 1'b0;
		low_power = 1'b0;
		next_st   = st;
		next_st.sync1  = wake_pin;
		next_st.sync2  = st.sync1;
		next_st.async1 = aux_wake_pin;
		next_st.async2 = st.async1;
		next_st.ton_d  = timer_on;
		next_st.sleep_d = sleep_request;
		low_power = (st.mode == wim_pkg::WIM_SLEEP) || (st.mode == wim_pkg::WIM_FAILSAFE);
		// measurement gating of pins one and two
		gate = {1'b0, {2{st.ctrl.meas}}};

		for (int i = 0; i < N_WAKE; i++) begin
			fc  = st.ctrl.filter[2*i +: 2];
			cyc = fc[1];
			lim = (fc == `WIM_FLT_LONG) ? CW'(T_LONG_CYC) : CW'(T_SHORT_CYC);
			c   = st.cnt[i*CW +: CW];
			smp = st.ton_d[fc[0]] && !timer_on[fc[0]]; // on-time end
			if (gate[i]) begin
				c = '0;
			end else if (st.sync2[i] == st.stable[i]) begin
				c = '0; // re-crossing restarts filter
			end else if (!cyc || timer_on[fc[0]] || smp) begin
				if (c + CW'(1) >= lim) begin
					// cyclic holds the count at lim - 1 until the window closes
					c = cyc ? (lim - CW'(1)) : CW'(0);
					if (!cyc) begin
						next_st.stable[i] = st.sync2[i];
						edge_hit[i] = 1'b1;
					end
				end else begin
					c = c + CW'(1);
				end
			end
			if (cyc && smp && !gate[i] && st.cnt[i*CW +: CW] + CW'(1) >= lim) begin
				next_st.stable[i] = st.sync2[i];
				edge_hit[i] = 1'b1;
			end
			next_st.cnt[i*CW +: CW] = c;
			if (!gate[i] && !low_power)
				next_st.level[i] = cyc ? next_st.stable[i] : st.sync2[i];
			p = pull_decode(st.ctrl.pull[2*i +: 2], st.stable[i]);
			next_st.pull_drive[2*i]   = p.pull_down & !gate[i];
			next_st.pull_drive[2*i+1] = p.pull_up & !gate[i];
		end

		for (int j = 0; j < N_AUX; j++) begin
			c = st.acnt[j*CW +: CW];
			if (st.async2[j] == st.astable[j]) begin
				c = '0;
			end else if (c + CW'(1) >= CW'(T_SHORT_CYC)) begin
				c = '0;
				next_st.astable[j] = st.async2[j];
				aux_hit[j] = 1'b1;
			end else begin
				c = c + CW'(1);
			end
			next_st.acnt[j*CW +: CW] = c;
		end

		// bus: write address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_got = 1'b1;
			next_st.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_got = 1'b1;
			next_st.wdata = s_axi_wdata;
			next_st.wstrb = s_axi_wstrb;
		end
		do_wr = st.aw_got && st.w_got && !st.bvalid;
		if (do_wr) begin
			next_st.aw_got = 1'b0;
			next_st.w_got  = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp  = known_offset(st.awaddr) ? `WIM_RESP_OKAY : `WIM_RESP_SLVERR;
			if (st.wstrb[0]) begin
				unique case (st.awaddr)
					`WIM_OFS_ENABLE:   next_st.ctrl.enable = st.wdata[2:0];
					`WIM_OFS_PULL:     next_st.ctrl.pull = st.wdata[5:0];
					`WIM_OFS_FILTER:   next_st.ctrl.filter = st.wdata[5:0];
					`WIM_OFS_SRC:      clr_src = st.wdata[N_WAKE-1:0];
					`WIM_OFS_AUX_SRC:  clr_aux = st.wdata[N_AUX-1:0];
					`WIM_OFS_MODE: begin
						next_st.mode = wim_pkg::wim_mode_t'(st.wdata[1:0]);
						next_st.ctrl.meas = st.wdata[`WIM_MODE_MEAS_BIT];
						if (st.wdata[`WIM_MODE_FAIL_BIT])
							next_st.fail = 1'b0;
					end
					`WIM_OFS_MASK:     next_st.ctrl.irq_mask = st.wdata[2:0];
					`WIM_OFS_AUX_MASK: next_st.ctrl.aux_mask = st.wdata[N_AUX-1:0];
					default: ;
				endcase
			end
		end
		if (st.bvalid && s_axi_bready)
			next_st.bvalid = 1'b0;

		// sticky flags: set wins over clear
		next_st.src     = (st.src & ~clr_src) | enabled_hits(edge_hit, st.ctrl.enable, gate);
		next_st.aux_src = (st.aux_src & ~clr_aux) | aux_hit;

		// refused sleep under measurement with only pins one/two enabled
		if (sleep_request && !st.sleep_d && st.ctrl.meas && st.ctrl.enable[2] == 1'b0
			&& st.ctrl.enable[1:0] != 2'h0) begin
			next_st.fail = 1'b1;
			next_st.restart = 1'b1;
			next_st.mode = wim_pkg::WIM_NORMAL;
		end else begin
			next_st.restart = 1'b0;
			if (sleep_request && !st.sleep_d)
				next_st.mode = wim_pkg::WIM_SLEEP;
		end

		// event routing by mode
		next_st.wake_up = low_power
			&& ((|enabled_hits(edge_hit, st.ctrl.enable, gate)) || (|aux_hit));
		next_st.irq = !low_power && ((|(next_st.src & st.ctrl.irq_mask))
			|| (|(next_st.aux_src & st.ctrl.aux_mask)));
		if (next_st.wake_up)
			next_st.mode = wim_pkg::WIM_NORMAL;

		if (s_axi_arvalid && s_axi_arready) begin
			unique case (s_axi_araddr)
				`WIM_OFS_ENABLE:   rd[2:0] = st.ctrl.enable;
				`WIM_OFS_PULL:     rd[5:0] = st.ctrl.pull;
				`WIM_OFS_FILTER:   rd[5:0] = st.ctrl.filter;
				`WIM_OFS_SRC:      rd[N_WAKE-1:0] = st.src;
				`WIM_OFS_AUX_SRC:  rd[N_AUX-1:0] = st.aux_src;
				`WIM_OFS_LEVEL:    rd[N_WAKE-1:0] = st.level;
				`WIM_OFS_MODE:     rd[4:0] = {st.fail, st.ctrl.meas, 1'b0, st.mode};
				`WIM_OFS_MASK:     rd[2:0] = st.ctrl.irq_mask;
				`WIM_OFS_AUX_MASK: rd[N_AUX-1:0] = st.ctrl.aux_mask;
				default:           rd = '0;
			endcase
			next_st.rvalid = 1'b1;
			next_st.rdata  = rd;
			next_st.rresp  = known_offset(s_axi_araddr) ? `WIM_RESP_OKAY : `WIM_RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end

		// readies registered from the next channel state
		next_st.awready = !next_st.aw_got && !next_st.bvalid;
		next_st.wready  = !next_st.w_got && !next_st.bvalid;
		next_st.arready = !next_st.rvalid;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			st <= '0;
		else
			st <= next_st;
	end

	assign s_axi_awready = st.awready;
	assign s_axi_wready  = st.wready;
	assign s_axi_arready = st.arready;
	assign s_axi_bvalid  = st.bvalid;
	assign s_axi_bresp   = st.bresp;
	assign s_axi_rvalid  = st.rvalid;
	assign s_axi_rdata   = st.rdata;
	assign s_axi_rresp   = st.rresp;
	assign pull_drive    = st.pull_drive;
	assign wake_up       = st.wake_up;
	assign restart       = st.restart;
	assign irq           = st.irq;
endmodule : wim_wake_input_monitor

// [bench/wim_wake_side.sv]
// far-side model: wake switches, aux inputs and the timer-fed supply window
// assumes bench commands; every line moves just after a rising edge
`timescale 1ns/100ps
module wim_wake_side (
	input  wire logic       clk,
	input  wire logic [2:0] lvl,
	input  wire logic [1:0] aux_lvl,
	input  wire logic [1:0] win,
	output logic      [2:0] wake_pin,
	output logic      [1:0] aux_wake_pin,
	output logic      [1:0] timer_on
);
	always_ff @(posedge clk) begin
		wake_pin     <= lvl;
		aux_wake_pin <= aux_lvl;
		timer_on     <= win; // window also powers the sensed circuit
	end
endmodule : wim_wake_side

// [bench/wim_checker.sv]
// assertions on the wake input monitor ports
// assumes one clock domain and the bind at the foot of this file
`timescale 1ns/100ps
module wim_checker #(
	parameter int N_WAKE      = 3,
	parameter int N_AUX       = 2,
	parameter int T_SHORT_CYC = 8
) (
	input wire logic                clk,
	input wire logic                reset_n,
	input wire logic [N_WAKE-1:0]   wake_pin,
	input wire logic [N_AUX-1:0]    aux_wake_pin,
	input wire logic                sleep_request,
	input wire logic [2*N_WAKE-1:0] pull_drive,
	input wire logic                wake_up,
	input wire logic                restart,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic [15:0]             quiet;
	logic [N_WAKE+N_AUX-1:0] pins_q;
	// cycles since any pin last moved
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			quiet  <= 16'h0000;
			pins_q <= '0;
		end else begin
			pins_q <= {aux_wake_pin, wake_pin};
			if (pins_q != {aux_wake_pin, wake_pin})
				quiet <= 16'h0000;
			else if (quiet != 16'hFFFF)
				quiet <= quiet + 16'h0001;
		end
	end
	sequence s_wr;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd;
		s_axi_arvalid && s_axi_arready;
	endsequence
	AST_WR_RESP: assert property (s_wr |-> ##[1:3] s_axi_bvalid)
		else $error("write answer missing");
	AST_RD_RESP: assert property (s_rd |-> ##[1:2] s_axi_rvalid)
		else $error("read answer missing");
	AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer repeated");
	AST_PULL_EXCL: assert property (((pull_drive >> 1) & pull_drive & {N_WAKE{2'h1}}) == '0)
		else $error("pull up and down together");
	AST_WAKE_PULSE: assert property (wake_up |=> !wake_up)
		else $error("wake pulse too long");
	AST_WAKE_FILTER: assert property (wake_up |-> quiet >= T_SHORT_CYC)
		else $error("wake before filter time");
	AST_RESTART_CAUSE: assert property (restart |-> $past(sleep_request) && !$past(sleep_request, 2))
		else $error("restart without sleep command");
	AST_RESTART_PULSE: assert property (restart |=> !restart)
		else $error("restart pulse too long");
endmodule : wim_checker
bind wim_wake_input_monitor wim_checker #(
	.N_WAKE      (N_WAKE),
	.N_AUX       (N_AUX),
	.T_SHORT_CYC (T_SHORT_CYC)
) i_wim_checker (
	.clk           (clk),
	.reset_n       (reset_n),
	.wake_pin      (wake_pin),
	.aux_wake_pin  (aux_wake_pin),
	.sleep_request (sleep_request),
	.pull_drive    (pull_drive),
	.wake_up       (wake_up),
	.restart       (restart),
	.s_axi_awvalid (s_axi_awvalid),
	.s_axi_awready (s_axi_awready),
	.s_axi_wvalid  (s_axi_wvalid),
	.s_axi_wready  (s_axi_wready),
	.s_axi_bvalid  (s_axi_bvalid),
	.s_axi_bready  (s_axi_bready),
	.s_axi_arvalid (s_axi_arvalid),
	.s_axi_arready (s_axi_arready),
	.s_axi_rvalid  (s_axi_rvalid),
	.s_axi_rready  (s_axi_rready)
);

// [bench/tb.sv]
// testbench for the wake input monitor: register bus, pins, modes
// assumes wim_wake_side drives pins and timer windows
`timescale 1ns/100ps
module tb;
	logic        clk, reset_n, sleep_request, wake_up, restart, irq, woke, restarted;
	logic [2:0]  lvl, wake_pin;
	logic [1:0]  aux_lvl, win, aux_wake_pin, timer_on, s_axi_bresp, s_axi_rresp, resp;
	logic [5:0]  pull_drive;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
	logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	int          bad_count, n_tests;
	wim_wake_input_monitor #(
		.T_SHORT_CYC (8),
		.T_LONG_CYC  (32)
	) i_wim_wake_input_monitor (
		.clk           (clk),
		.reset_n       (reset_n),
		.wake_pin      (wake_pin),
		.aux_wake_pin  (aux_wake_pin),
		.timer_on      (timer_on),
		.sleep_request (sleep_request),
		.pull_drive    (pull_drive),
		.wake_up       (wake_up),
		.restart       (restart),
		.irq           (irq),
		.s_axi_awaddr  (s_axi_awaddr),
		.s_axi_awvalid (s_axi_awvalid),
		.s_axi_awready (s_axi_awready),
		.s_axi_wdata   (s_axi_wdata),
		.s_axi_wstrb   (s_axi_wstrb),
		.s_axi_wvalid  (s_axi_wvalid),
		.s_axi_wready  (s_axi_wready),
		.s_axi_bresp   (s_axi_bresp),
		.s_axi_bvalid  (s_axi_bvalid),
		.s_axi_bready  (s_axi_bready),
		.s_axi_araddr  (s_axi_araddr),
		.s_axi_arvalid (s_axi_arvalid),
		.s_axi_arready (s_axi_arready),
		.s_axi_rdata   (s_axi_rdata),
		.s_axi_rresp   (s_axi_rresp),
		.s_axi_rvalid  (s_axi_rvalid),
		.s_axi_rready  (s_axi_rready)
	);
	wim_wake_side i_wim_wake_side (
		.clk          (clk),
		.lvl          (lvl),
		.aux_lvl      (aux_lvl),
		.win          (win),
		.wake_pin     (wake_pin),
		.aux_wake_pin (aux_wake_pin),
		.timer_on     (timer_on)
	);
	always #2.5 clk = ~clk;
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			woke      <= 1'b0;
			restarted <= 1'b0;
		end else begin
			if (wake_up) woke <= 1'b1;
			if (restart) restarted <= 1'b1;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic ah, wh, bh;
		int   n;
		{s_axi_awaddr, s_axi_wdata} <= {a, d};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		bh = 1'b0;
		for (n = 0; !bh && n < 99; n++) begin
			@(negedge clk);
			{ah, wh, bh, resp} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge clk);
			if (ah) s_axi_awvalid <= 1'b0;
			if (wh) s_axi_wvalid <= 1'b0;
		end
		chk(bh, 1'b1);
	endtask : wr
	task automatic rd(input logic [11:0] a);
		logic ah, rh;
		int   n;
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		rh = 1'b0;
		for (n = 0; !rh && n < 99; n++) begin
			@(negedge clk);
			{ah, rh, rdat, resp} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge clk);
			if (ah) s_axi_arvalid <= 1'b0;
		end
		chk(rh, 1'b1);
	endtask : rd
	task automatic t_regs;
		rd(12'h004);
		chk(rdat, 32'h0);
		rd(12'h100);
		chk(resp, 2'h2);
		wr(12'h100, 32'h1);
		chk(resp, 2'h2);
		wr(12'h000, 32'h7);
		rd(12'h000);
		chk(rdat, 32'h7);
		wr(12'h01C, 32'h7);
	endtask : t_regs
	task automatic t_edges;
		lvl <= 3'h4;
		cyc(4);
		lvl <= 3'h0;
		cyc(20);
		rd(12'h00C);
		chk(rdat, 32'h0);
		lvl <= 3'h4;
		cyc(20);
		rd(12'h00C);
		chk(rdat, 32'h4);
		chk(irq, 1'b1);
		rd(12'h014);
		chk(rdat, 32'h4);
		wr(12'h00C, 32'h4);
		wr(12'h008, 32'h10);
		chk(irq, 1'b0);
		lvl <= 3'h0;
		cyc(20);
		rd(12'h00C);
		chk(rdat, 32'h0);
		cyc(30);
		rd(12'h00C);
		chk(rdat, 32'h4);
		wr(12'h00C, 32'h4);
	endtask : t_edges
	task automatic t_pull;
		for (int i = 0; i < 4; i++) begin
			wr(12'h004, i);
			cyc(6);
			chk(pull_drive[1:0], (i == 3) ? 1 : i);
		end
		lvl <= 3'h1;
		cyc(16);
		chk(pull_drive[1:0], 2'h2);
		lvl <= 3'h0;
		cyc(20);
		wr(12'h00C, 32'h7);
		wr(12'h004, 32'h0);
	endtask : t_pull
	task automatic t_cyclic;
		wr(12'h008, 32'h20);
		lvl <= 3'h4;
		cyc(30);
		rd(12'h00C);
		chk(rdat, 32'h0);
		rd(12'h014);
		chk(rdat, 32'h0);
		win <= 2'h1;
		cyc(20);
		win <= 2'h0;
		cyc(6);
		rd(12'h00C);
		chk(rdat, 32'h4);
		wr(12'h00C, 32'h4);
		wr(12'h008, 32'h0);
		aux_lvl <= 2'h1;
		cyc(20);
		rd(12'h010);
		chk(rdat, 32'h1);
	endtask : t_cyclic
	task automatic t_meas;
		wr(12'h018, 32'h8);
		wr(12'h004, 32'hA);
		cyc(6);
		chk(pull_drive[3:0], 4'h0);
		lvl <= 3'h5;
		cyc(20);
		rd(12'h00C);
		chk(rdat, 32'h0);
		rd(12'h014);
		chk(rdat, 32'h4);
		wr(12'h000, 32'h3);
		sleep_request <= 1'b1;
		cyc(6);
		chk(restarted, 1'b1);
		sleep_request <= 1'b0;
		rd(12'h018);
		chk(rdat[4], 1'b1);
		wr(12'h018, 32'h10);
		wr(12'h004, 32'h0);
	endtask : t_meas
	task automatic t_sleep;
		wr(12'h000, 32'h4);
		wr(12'h018, 32'h2);
		lvl <= 3'h1;
		cyc(20);
		chk(woke, 1'b1);
		rd(12'h00C);
		chk(rdat[2], 1'b1);
		wr(12'h00C, 32'h7);
		wr(12'h018, 32'h1);
		lvl <= 3'h5;
		cyc(20);
		chk(irq, 1'b1);
		wr(12'h00C, 32'h7);
		wr(12'h018, 32'h3);
		lvl <= 3'h1;
		cyc(20);
		rd(12'h018);
		chk(rdat[1:0], 2'h0);
	endtask : t_sleep
	task automatic complete_run;
		if (bad_count == 0 && n_tests > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run
	initial begin
		{clk, reset_n, sleep_request, lvl, aux_lvl, win} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid} = '0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready, bad_count, n_tests} = '0;
		s_axi_wstrb = 4'hF;
		cyc(4);
		reset_n <= 1'b1;
		cyc(1);
		t_regs;
		t_edges;
		t_pull;
		t_cyclic;
		t_meas;
		t_sleep;
		complete_run;
	end
	initial begin
		#200000;
		bad_count++;
		complete_run;
	end
endmodule : tb
